// *** rtl/tape_read_parity_checker.sv ***
// Vertical and longitudinal parity checker for data read back from tape
`timescale 1ns/100ps
`default_nettype none
module tape_read_parity_checker #(
   parameter int DISPLAY_CYCLES = tape_parity_pkg::DISPLAY_CYCLES
) (
   input  wire logic       sys_clk,             // 20 MHz system clock
   input  wire logic       reset_n,             // Async reset, active low
   input  wire logic       readClock,           // Read clock from tape unit
   input  wire logic [8:0] readData,            // Bit 8 parity track, 7..0 data tracks
   input  wire logic       sevenTrackMode,      // High selects seven-track operation
   input  wire logic       parity_sense_select, // High even check, low odd check
   input  wire logic       blockStart,          // Start pulse for the next block
   input  wire logic       checkCharRead,       // High while check character is read
   input  wire logic       endOfBlock,          // End-of-block pulse
   output logic            verticalError_r,     // Last sampled vertical result
   output logic            verticalLatch_r,     // Sticky vertical error
   output logic            longitudinalError_r, // OR of track flops
   output logic            displayActive_r,     // Display period running
   output logic [8:0]      trackLamp_r          // Per-track longitudinal lamps
);
   localparam int S = tape_parity_pkg::SYNC_STAGES;

   // Pin synchronisers; only the last stage is read by logic
   // The data bus is synchronised bit by bit, which is safe only because the tape
   // unit holds each character steady for several clocks around its strobe
   logic [S-1:0] clkSync_r;
   logic [S-1:0][8:0] dataSync_r;
   logic [S-1:0] startSync_r;
   logic [S-1:0] checkSync_r;
   logic [S-1:0] eobSync_r;
   logic [S-1:0] modeSync_r;
   logic [S-1:0] senseSync_r;
   logic         clkPrev_r;
   logic         startPrev_r;
   logic         eobPrev_r;
   logic [tape_parity_pkg::DISPLAY_W-1:0] displayCount_r;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         clkSync_r   <= '0;
         dataSync_r  <= '0;
         startSync_r <= '0;
         checkSync_r <= '0;
         eobSync_r   <= '0;
         modeSync_r  <= '0;
         senseSync_r <= '0;
      end else begin
         clkSync_r   <= {clkSync_r[S-2:0], readClock};
         dataSync_r  <= {dataSync_r[S-2:0], readData};
         startSync_r <= {startSync_r[S-2:0], blockStart};
         checkSync_r <= {checkSync_r[S-2:0], checkCharRead};
         eobSync_r   <= {eobSync_r[S-2:0], endOfBlock};
         modeSync_r  <= {modeSync_r[S-2:0], sevenTrackMode};
         senseSync_r <= {senseSync_r[S-2:0], parity_sense_select};
      end
   end

   // Edge detectors look only at the final sync stage
   // Reset values match the idle low pins, so no false edge follows reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         clkPrev_r   <= 1'b0;
         startPrev_r <= 1'b0;
         eobPrev_r   <= 1'b0;
      end else begin
         clkPrev_r   <= clkSync_r[S-1];
         startPrev_r <= startSync_r[S-1];
         eobPrev_r   <= eobSync_r[S-1];
      end
   end

   wire       readStrobe  = clkSync_r[S-1] & ~clkPrev_r;
   wire       startPulse  = startSync_r[S-1] & ~startPrev_r;
   wire       eobPulse    = eobSync_r[S-1] & ~eobPrev_r;
   wire       sevenMode   = modeSync_r[S-1];
   wire       evenSense   = senseSync_r[S-1];
   wire [8:0] sampled     = dataSync_r[S-1];

   // Seven-track mode forces tracks zero and one to one so they stay out of the count
   wire [8:0] checkedBits = sevenMode ? (sampled | ~tape_parity_pkg::SEVEN_TRACK_MASK)
                                      : sampled;
   wire       vertical_parity_tree = ^{checkedBits[tape_parity_pkg::PARITY_TRACK],
                                       checkedBits[7:tape_parity_pkg::TRACK_ONE]};
   wire       read_track_zero_bit  = checkedBits[tape_parity_pkg::TRACK_ZERO];
   // Track zero set inverts the tree: an even tree count then means an odd total
   wire       totalOnesOdd = read_track_zero_bit ? ~vertical_parity_tree
                                                 : vertical_parity_tree;
   wire       charError    = evenSense ? totalOnesOdd : ~totalOnesOdd;
   wire       sampleVert   = readStrobe & ~checkSync_r[S-1];

   // Vertical result holds between strobes; latch set wins over a start clear
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         verticalError_r <= 1'b0;
         verticalLatch_r <= 1'b0;
      end else begin
         if (sampleVert) verticalError_r <= charError;
         if (sampleVert && charError) verticalLatch_r <= 1'b1;
         else if (startPulse) verticalLatch_r <= 1'b0;
      end
   end

   // Nine longitudinal toggle flops share one strobe and one sample
   // In seven-track mode tracks zero and one see forced ones, so their lamps mean
   // nothing there; only nine-track blocks give a full longitudinal result
   track_bus_if trackBus ();
   assign trackBus.clearAll = startPulse;
   assign trackBus.strobe   = readStrobe;
   assign trackBus.bits     = checkedBits;

   for (genvar t = 0; t < tape_parity_pkg::TRACKS; t++) begin : g_track
      track_toggle_flop #(.TRACK(t)) u_flop (
         .sys_clk (sys_clk),
         .reset_n (reset_n),
         .bus     (trackBus.flop)
      );
   end

   wire       longitudinal_error_or = |trackBus.state;
   wire       displayDone = (displayCount_r == '0);
   wire [8:0] lamp_nxt    = (displayActive_r && !displayDone) ? trackBus.state : 9'h000;

   // Display timer runs one period from the end-of-block pulse
   // A new end-of-block pulse restarts the period; lamps light one cycle late and go dark with it
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         displayActive_r <= 1'b0;
         displayCount_r  <= '0;
      end else if (eobPulse) begin
         displayActive_r <= 1'b1;
         displayCount_r  <= tape_parity_pkg::DISPLAY_W'(DISPLAY_CYCLES - 1);
      end else if (displayActive_r) begin
         displayActive_r <= !displayDone;
         displayCount_r  <= displayDone ? displayCount_r : displayCount_r - 1'b1;
      end
   end

   // Lamps and combined error are registered so outputs come from flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         trackLamp_r         <= 9'h000;
         longitudinalError_r <= 1'b0;
      end else begin
         trackLamp_r         <= lamp_nxt;
         longitudinalError_r <= longitudinal_error_or;
      end
   end

   // Checks on the design's own behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_vert_even_err: assert property (sampleVert && evenSense && totalOnesOdd |=> verticalError_r)
      else $error("even sense missed odd character");
   a_vert_odd_pass: assert property (sampleVert && !evenSense && totalOnesOdd |=> !verticalError_r)
      else $error("odd sense flagged odd character");
   a_vert_hold: assert property (!sampleVert |=> $stable(verticalError_r))
      else $error("vertical result changed without strobe");
   a_seven_ignore: assert property (sevenMode |-> totalOnesOdd == ^sampled[8:2])
      else $error("seven-track count used tracks zero or one");
   a_check_inhibit: assert property (checkSync_r[S-1] && !verticalLatch_r && !startPulse
                                     |=> !verticalLatch_r)
      else $error("latch set during check character");
   a_latch_sticky: assert property (verticalLatch_r && !startPulse |=> verticalLatch_r)
      else $error("vertical latch dropped without start");
   a_start_clear: assert property (startPulse && !readStrobe |=> trackBus.state == 9'h000)
      else $error("start did not clear track flops");
   a_track_toggle: assert property (!startPulse |=> trackBus.state ==
                                    ($past(trackBus.state) ^ ($past(readStrobe) ? $past(checkedBits) : 9'h000)))
      else $error("track flop did not follow one bits");
   a_lamp_gate: assert property (!displayActive_r |=> trackLamp_r == 9'h000)
      else $error("lamp lit outside display period");
   a_or_error: assert property (##1 longitudinalError_r == |$past(trackBus.state))
      else $error("combined error wrong");
   a_display_len: assert property (eobPulse |=> displayActive_r [*8])
      else $error("display period ended early");

   // Latch, vertical, lamp and display timer checks around the block boundaries
   a_latch_set: assert property (sampleVert && charError |=> verticalLatch_r)
      else $error("vertical error did not set latch");
   a_start_latch: assert property (startPulse && !(sampleVert && charError) |=> !verticalLatch_r)
      else $error("start did not clear vertical latch");
   a_vert_inhibit: assert property (checkSync_r[S-1] && readStrobe |=> $stable(verticalError_r))
      else $error("vertical result sampled during check character");
   a_lamp_follow: assert property (displayActive_r && !displayDone
                                   |=> trackLamp_r == $past(trackBus.state))
      else $error("lamps did not follow track flops");
   a_display_load: assert property (eobPulse
                                    |=> displayCount_r == tape_parity_pkg::DISPLAY_W'(DISPLAY_CYCLES - 1))
      else $error("display timer not loaded");
   a_display_stop: assert property (displayActive_r && displayDone && !eobPulse |=> !displayActive_r)
      else $error("display period overran");

   // Main scenarios the bench should reach
   c_vert_error:  cover property (sampleVert && charError);
   c_block_pass:  cover property (eobPulse && trackBus.state == 9'h000);
   c_track_fail:  cover property (displayActive_r && |trackBus.state);
   c_seven_mode:  cover property (sevenMode && readStrobe);
   c_check_char:  cover property (checkSync_r[S-1] && readStrobe);
endmodule
`default_nettype wire

// *** rtl/tape_parity_pkg.sv ***
// Shared constants for the tape read parity checker
package tape_parity_pkg;
   localparam int TRACKS          = 9;          // Parity track plus eight data tracks
   localparam int PARITY_TRACK    = 8;          // Bit index of the parity track
   localparam int TRACK_ZERO      = 0;          // Bit index of data track zero
   localparam int TRACK_ONE       = 1;          // Bit index of data track one
   localparam int SYNC_STAGES     = 2;          // Flops ahead of any logic on pins
   localparam int CLK_HZ          = 20000000;   // System clock rate
   localparam int DISPLAY_MS      = 250;        // Display period length
   localparam int DISPLAY_CYCLES  = (CLK_HZ / 1000) * DISPLAY_MS;
   localparam int DISPLAY_W       = 23;         // Wide enough for DISPLAY_CYCLES
   localparam logic [8:0] SEVEN_TRACK_MASK = 9'h1FC; // Tracks zero and one excluded
endpackage

// *** rtl/track_bus_if.sv ***
// Interface between the track controller and the per-track toggle flops
`timescale 1ns/100ps
`default_nettype none
interface track_bus_if;
   logic       clearAll;   // Block start clear pulse
   logic       strobe;     // One cycle per read clock rising edge
   logic [8:0] bits;       // Sampled track bits
   logic [8:0] state;      // Toggle flop states
   modport ctrl (output clearAll, output strobe, output bits, input state);
   modport flop (input clearAll, input strobe, input bits, output state);
endinterface
`default_nettype wire

// *** rtl/track_toggle_flop.sv ***
// One longitudinal parity toggle flop for a single track
`timescale 1ns/100ps
`default_nettype none
module track_toggle_flop #(
   parameter int TRACK = 0
) (
   input  wire logic    sys_clk,   // System clock
   input  wire logic    reset_n,   // Async reset, active low
   track_bus_if.flop    bus        // Shared track signals
);
   wire oneSeen = bus.strobe & bus.bits[TRACK];
   logic state_r;

   // Clear wins over held state, but a one on the same strobe still counts
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= 1'b0;
      end else if (bus.clearAll) begin
         state_r <= oneSeen;
      end else begin
         state_r <= state_r ^ oneSeen;
      end
   end
   assign bus.state[TRACK] = state_r;
endmodule
`default_nettype wire

// *** bench/tape_read_model.sv ***
// Behavioural tape unit read electronics: characters, read strobe and check character
`timescale 1ns/100ps
`default_nettype none
module tape_read_model (
   output logic       readClock,  // Read strobe, still between characters
   output logic [8:0] readData,   // Track bits, bit 8 parity track
   input  wire logic  sevenTrack  // Seven-track operation
);
   logic [8:0] blockSum;          // Running track sums for the check character

   // Lines idle low until the first character
   initial begin
      readClock = 1'b0;
      readData  = 9'h000;
      blockSum  = 9'h000;
   end

   // Setup and hold of 200 ns each side of the strobe; afterwards the data is
   // inverted so a checker that samples late cannot pass by luck
   task automatic sendChar(input logic [8:0] ch);
      logic [8:0] d;
      d = sevenTrack ? (ch | 9'h003) : ch;
      readData = d;
      #200 readClock = 1'b1;
      #200 readClock = 1'b0;
      #200 readData = ~d;
   endtask

   // Data character, counted into the track sums
   task automatic dataChar(input logic [8:0] ch);
      blockSum = blockSum ^ ch;
      sendChar(ch);
   endtask

   // Check character evens every track in nine-track mode; spoil leaves chosen tracks odd on purpose
   task automatic checkChar(input logic [8:0] spoil);
      sendChar(blockSum ^ spoil);
      blockSum = 9'h000;
   endtask
endmodule
`default_nettype wire

// *** bench/tb_tape_read_parity_checker.sv ***
// Self-checking bench for the tape read parity checker
`timescale 1ns/100ps
`default_nettype none
module tb_tape_read_parity_checker;
   localparam int DISP = 20;  // Shortened display period keeps the run brief
   logic       sys_clk = 1'b0, reset_n = 1'b0, sevenTrack = 1'b0, evenSense = 1'b0;
   logic       blockStart = 1'b0, checkCharRead = 1'b0, endOfBlock = 1'b0;
   logic       readClock, vErr, vLatch, lErr, dispOn, expLatch;
   logic [8:0] readData, lamps, ch, spoil;
   int         failures = 0, n_tests = 0;

   always #25 sys_clk = ~sys_clk;

   tape_read_model i_tape (.readClock(readClock), .readData(readData), .sevenTrack(sevenTrack));
   tape_read_parity_checker #(.DISPLAY_CYCLES(DISP)) i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .readClock(readClock), .readData(readData),
      .sevenTrackMode(sevenTrack), .parity_sense_select(evenSense), .blockStart(blockStart),
      .checkCharRead(checkCharRead), .endOfBlock(endOfBlock), .verticalError_r(vErr),
      .verticalLatch_r(vLatch), .longitudinalError_r(lErr), .displayActive_r(dispOn),
      .trackLamp_r(lamps));

   // Comparisons for single levels and for track vectors
   task automatic cmp1(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cmp9(input string what, input logic [8:0] exp, input logic [8:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Expected vertical level: odd one count against the selected sense
   function automatic logic vExp(input logic [8:0] c, input logic seven, input logic even);
      logic [8:0] e;
      e = seven ? (c | 9'h003) : c;
      return (^e) ^ ~even;
   endfunction

   // Block control pulse, three clocks wide so the synchroniser cannot miss it
   task automatic pulse(input logic eob);
      @(posedge sys_clk);
      if (eob) endOfBlock <= 1'b1;
      else blockStart <= 1'b1;
      repeat (3) @(posedge sys_clk);
      endOfBlock <= 1'b0;
      blockStart <= 1'b0;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h9f8a));
      expLatch = 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      cmp1("vertical after reset", 1'b0, vErr);
      cmp1("display after reset", 1'b0, dispOn);
      // All-ones corner in both senses, then random characters in both modes
      for (int i = 0; i < 24; i++) begin
         @(posedge sys_clk);
         evenSense <= (i < 2) ? i[0] : 1'($urandom);
         sevenTrack <= (i < 2) ? 1'b0 : 1'($urandom);
         ch = (i < 2) ? 9'h1FF : 9'($urandom);
         @(negedge sys_clk);
         i_tape.sendChar(ch);
         expLatch = expLatch | vExp(ch, sevenTrack, evenSense);
         cmp1("vertical result", vExp(ch, sevenTrack, evenSense), vErr);
         cmp1("vertical latch", expLatch, vLatch);
      end
      @(posedge sys_clk);
      sevenTrack <= 1'b0;
      // Blocks with clean, parity-track, boundary and random spoilt tracks
      for (int b = 0; b < 4; b++) begin
         spoil = (b == 3) ? 9'($urandom) : (b == 0) ? 9'h000 : (b == 1) ? 9'h100 : 9'h003;
         pulse(1'b0);
         repeat (5) @(posedge sys_clk);
         cmp1("latch cleared", 1'b0, vLatch);
         cmp1("longitudinal cleared", 1'b0, lErr);
         expLatch = 1'b0;
         for (int i = 0; i < 10; i++) begin
            ch = 9'($urandom);
            @(negedge sys_clk);
            i_tape.dataChar(ch);
            expLatch = expLatch | vExp(ch, 1'b0, evenSense);
         end
         @(posedge sys_clk);
         checkCharRead <= 1'b1;
         repeat (4) @(posedge sys_clk);
         @(negedge sys_clk);
         i_tape.checkChar(spoil);
         cmp1("vertical held over check char", vExp(ch, 1'b0, evenSense), vErr);
         @(posedge sys_clk);
         checkCharRead <= 1'b0;
         repeat (4) @(posedge sys_clk);
         cmp1("latch after block", expLatch, vLatch);
         cmp1("combined error", |spoil, lErr);
         cmp9("lamps before display", 9'h000, lamps);
         pulse(1'b1);
         for (int k = 0; k < 10 && dispOn !== 1'b1; k++) @(posedge sys_clk);
         if (dispOn !== 1'b1) begin
            $display("[ERR] display start expected 1 seen %b", dispOn);
            failures++;
            wrap_up();
         end
         repeat (2) @(posedge sys_clk);
         cmp9("lamps in display", spoil, lamps);
         repeat (DISP - 8) @(posedge sys_clk);
         cmp1("display still on", 1'b1, dispOn);
         repeat (10) @(posedge sys_clk);
         cmp1("display ended", 1'b0, dispOn);
         cmp9("lamps after display", 9'h000, lamps);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
